//--- rtl/mspc_pkg.sv
// constants shared by the monitor status and pin control block
// assumes a 100 MHz system clock and a decoded register access port
package mspc_pkg;

    // register addresses
    localparam logic [7:0] ADDR_CFG1      = 8'h00;
    localparam logic [7:0] ADDR_CFG2      = 8'h01;
    localparam logic [7:0] ADDR_STATUS    = 8'h02;
    localparam logic [7:0] ADDR_SHUNT_POS = 8'h0c;
    localparam logic [7:0] ADDR_SHUNT_NEG = 8'h0d;
    localparam logic [7:0] ADDR_BUS_POS   = 8'h0e;
    localparam logic [7:0] ADDR_BUS_NEG   = 8'h0f;
    localparam logic [7:0] ADDR_PWR_LIM   = 8'h10;
    localparam logic [7:0] ADDR_LOCAL_LIM = 8'h11;

    // field positions
    localparam int CFG1_ONESHOT = 14;
    localparam int MODE_MSB     = 2;
    localparam int MODE_LSB     = 0;
    localparam int CFG2_CONT    = 15;
    localparam int EN_MSB       = 14;
    localparam int EN_LSB       = 11;
    localparam int RATE_MSB     = 9;
    localparam int RATE_LSB     = 7;
    localparam int PIN_BIT      = 2;
    localparam int PMODE_MSB    = 1;
    localparam int PMODE_LSB    = 0;
    localparam int ST_SHUNT_OVR = 15;
    localparam int ST_SHUNT_UND = 14;
    localparam int ST_BUS_OVR   = 13;
    localparam int ST_BUS_UND   = 12;
    localparam int ST_PWR_OVR   = 11;
    localparam int ST_LOCAL     = 10;

    // reset values and write masks
    localparam logic [15:0] CFG1_RESET  = 16'h0007;
    localparam logic [15:0] CFG1_WMASK  = 16'hbfff;
    localparam logic [15:0] CFG2_RESET  = 16'hff80;
    localparam logic [15:0] CFG2_WMASK  = 16'hff83;
    localparam logic [15:0] STAT_RESET  = 16'h0000;
    localparam logic [15:0] POS_RESET   = 16'h7fff;
    localparam logic [15:0] NEG_RESET   = 16'h8000;
    localparam logic [15:0] UPOS_RESET  = 16'hffff;
    localparam logic [15:0] UNEG_RESET  = 16'h0000;
    localparam logic [15:0] HYST_RESET  = 16'h0008;

    // codes
    localparam logic [2:0] RATE_FASTEST = 3'h7;
    localparam logic [1:0] PMODE_LOW    = 2'h2;
    localparam logic [1:0] PMODE_HIGH   = 2'h3;

    // conversion intervals in ms per rate code, and per-channel slot
    localparam logic [14:0] RATE_MS [0:7] = '{15'h3e80, 15'h1f40,
        15'h0fa0, 15'h07d0, 15'h03e8, 15'h01f4, 15'h00fa, 15'h007d};
    localparam logic [14:0] SLOT_MS = 15'h007d;

    // timing: one interval tick per millisecond
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_TIME_US  = 1000;
    localparam int TICK_CYCLES   = TICK_TIME_US * 1000 / CLK_PERIOD_NS;

endpackage : mspc_pkg

//--- rtl/mspc_flag_if.sv
// carrier between the control module and the limit flag module
// assumes both ends share ref_clk
`timescale 1ns/10ps
`default_nettype none
interface mspc_flag_if;
    logic        conv_end;
    logic        latch_mode;
    logic        read_clr;
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] power;
    logic [15:0] local_t;
    logic [15:0] lim_shunt_pos;
    logic [15:0] lim_shunt_neg;
    logic [15:0] lim_bus_pos;
    logic [15:0] lim_bus_neg;
    logic [15:0] lim_pwr;
    logic [15:0] lim_local;
    logic [15:0] hyst;
    logic [15:0] flags;

    modport ctrl (output conv_end, latch_mode, read_clr, shunt, bus, power,
                  local_t, lim_shunt_pos, lim_shunt_neg, lim_bus_pos,
                  lim_bus_neg, lim_pwr, lim_local, hyst, input flags);
    modport flagger (input conv_end, latch_mode, read_clr, shunt, bus,
                     power, local_t, lim_shunt_pos, lim_shunt_neg,
                     lim_bus_pos, lim_bus_neg, lim_pwr, lim_local, hyst,
                     output flags);
endinterface : mspc_flag_if
`default_nettype wire

//--- rtl/mspc_limit_flags.sv
// limit comparators and the status flags in latch or transparent mode
// assumes results are held between conversion-end pulses
`timescale 1ns/10ps
`default_nettype none
module mspc_limit_flags (
    input wire logic    ref_clk,
    input wire logic    nrst,
    mspc_flag_if.flagger fi
);
    logic [15:0] flags_r;
    logic [15:0] flags_nxt;
    logic [5:0]  viol;
    logic        temp_hi;
    logic        temp_lo;
    logic [16:0] lim_hi;
    logic [16:0] lim_lo;

    localparam logic [15:0] STAT_ZERO = mspc_pkg::STAT_RESET;

    // all checks below run on ref_clk and sleep in reset
    default clocking cb_flags @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    assign fi.flags = flags_r;

    ////////////////////////////////////////////////////////////////////
    // comparators; shunt and temperature are signed, bus and power not
    always_comb begin
        lim_hi = {fi.lim_local[15], fi.lim_local}
               + {2'h0, fi.hyst[15:1]};
        lim_lo = {fi.lim_local[15], fi.lim_local}
               - {2'h0, fi.hyst[15:1]};
        viol[5] = $signed(fi.shunt) > $signed(fi.lim_shunt_pos); // RQ12
        viol[4] = $signed(fi.shunt) < $signed(fi.lim_shunt_neg); // RQ13
        viol[3] = fi.bus > fi.lim_bus_pos; // RQ14
        viol[2] = fi.bus < fi.lim_bus_neg; // RQ15
        viol[1] = fi.power > fi.lim_pwr; // RQ16
        temp_hi = $signed({fi.local_t[15], fi.local_t}) > $signed(lim_hi);
        temp_lo = $signed({fi.local_t[15], fi.local_t}) < $signed(lim_lo);
        viol[0] = temp_hi;
    end

    ////////////////////////////////////////////////////////////////////
    // flag update; a set at conversion end wins over a read clear
    always_comb begin
        flags_nxt = flags_r;
        if (fi.latch_mode) begin
            if (fi.read_clr) begin
                flags_nxt = STAT_ZERO; // RQ9 RQ19
            end
            if (fi.conv_end) begin
                flags_nxt[15:10] = flags_nxt[15:10] | viol; // RQ9
            end
        end else begin
            flags_nxt[15:11] = viol[5:1]; // RQ10
            if (temp_hi) begin
                flags_nxt[mspc_pkg::ST_LOCAL] = 1'b1; // RQ17
            end else if (temp_lo) begin
                flags_nxt[mspc_pkg::ST_LOCAL] = 1'b0; // RQ17
            end
        end
    end

    // flag register
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            flags_r <= mspc_pkg::STAT_RESET; // RQ8
        end else begin
            flags_r <= flags_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    a_latch_hold: assert property ( // RQ9
        fi.latch_mode && !fi.read_clr ##1 fi.latch_mode
        |-> (flags_r & $past(flags_r)) == $past(flags_r))
        else $error("latched flag dropped without read");
    a_latch_clear: assert property ( // RQ9
        fi.latch_mode && fi.read_clr && !fi.conv_end
        |=> flags_r == 16'h0000)
        else $error("status read did not clear latched flags");
    a_transp_follow: assert property ( // RQ10
        !fi.latch_mode |=> flags_r[15:11] == $past(viol[5:1]))
        else $error("transparent flags do not follow limits");
    a_shunt_over: assert property ( // RQ12
        fi.conv_end && ($signed(fi.shunt) > $signed(fi.lim_shunt_pos))
        |=> flags_r[mspc_pkg::ST_SHUNT_OVR])
        else $error("shunt over-limit flag not set");
    a_temp_hyst: assert property ( // RQ17
        !fi.latch_mode && !temp_hi && !temp_lo ##1 !fi.latch_mode
        |-> flags_r[mspc_pkg::ST_LOCAL]
            == $past(flags_r[mspc_pkg::ST_LOCAL]))
        else $error("temperature flag moved inside hysteresis band");
    c_latch_set: cover property (
        fi.latch_mode && fi.conv_end && viol[5] ##1 fi.read_clr);
    c_transp_clear: cover property (
        !fi.latch_mode && flags_r[mspc_pkg::ST_BUS_UND] ##1 !viol[2]);
endmodule : mspc_limit_flags
`default_nettype wire

//--- rtl/mspc_monitor_ctrl.sv
// control and status logic of the temperature and supply monitor
// assumes a decoded register port from the two-wire slave, synchronous
// pin input, and conversion results held by the analog front end
//
// Requirements on this block, the board and the host
// RQ1: rate 4/s gives 2 2/3 per second at three, 2 at four channels
// RQ2: rate 8/s gives 4 per second at two, 2 2/3 at three channels
// RQ3: temperature tick starts one voltage conversion if rate not fastest
// RQ4: config bit 2 is read-only and shows the sensed pin level
// RQ5: pin mode 00 or 01 leaves the pin undriven; 00 after reset
// RQ6: pin mode 10 drives the pin low, 11 drives it high
// RQ7: board must not leave the pin floating at start-up
// RQ8: sixteen-bit status register at 02h, zero after reset
// RQ9: latch mode holds flags until status read, sets again if violated
// RQ10: transparent mode drops flags once the limit is no longer violated
// RQ11: host reads status once after power-up and setup
// RQ12: bit 15 set when shunt result exceeds shunt positive limit
// RQ13: bit 14 set when shunt result falls below shunt negative limit
// RQ14: bit 13 set when bus result exceeds bus positive limit
// RQ15: bit 12 set when bus result falls below bus negative limit
// RQ16: bit 11 set when power result exceeds power limit
// RQ17: local flag sets above limit plus half hysteresis, clears below minus
// RQ18: triggered voltage modes stay powered down until a start
// RQ19: status read returns flags before the clear takes effect
`timescale 1ns/10ps
`default_nettype none
module mspc_monitor_ctrl #(
    parameter int TICK_CYCLES = mspc_pkg::TICK_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    input  wire logic        latch_mode,
    input  wire logic        conv_end,
    input  wire logic [15:0] shunt_result,
    input  wire logic [15:0] bus_result,
    input  wire logic [15:0] power_result,
    input  wire logic [15:0] local_result,
    input  wire logic        pin_in,
    output logic             pin_out,
    output logic             pin_oe,
    output logic             temp_conv_tick,
    output logic             volt_start,
    output logic             volt_off
);
    localparam int TW = $clog2(TICK_CYCLES + 1);

    mspc_flag_if fi ();

    logic [15:0] cfg1_r, cfg1_nxt;
    logic [15:0] cfg2_r, cfg2_nxt;
    logic [15:0] lsp_r, lsp_nxt;
    logic [15:0] lsn_r, lsn_nxt;
    logic [15:0] lbp_r, lbp_nxt;
    logic [15:0] lbn_r, lbn_nxt;
    logic [15:0] lpw_r, lpw_nxt;
    logic [15:0] llc_r, llc_nxt;
    logic [15:0] rd_data_r, rd_data_nxt;
    logic        rd_valid_r, rd_valid_nxt;
    logic        pin_lvl_r, pin_lvl_nxt;
    logic        pin_out_r, pin_out_nxt;
    logic        pin_oe_r, pin_oe_nxt;
    logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
    logic [14:0] ms_cnt_r, ms_cnt_nxt;
    logic        tick_r, tick_nxt;
    logic        vstart_r, vstart_nxt;
    logic        voff_r, voff_nxt;
    logic        ms_tick;
    logic        temp_run;
    logic        one_shot;
    logic [2:0]  nch;
    logic [14:0] interval;
    logic [2:0]  mode_now;

    // all checks below run on ref_clk and sleep in reset
    default clocking cb_ctrl @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [2:0] chan_count(input logic [3:0] en);
        chan_count = {2'h0, en[0]} + {2'h0, en[1]}
                   + {2'h0, en[2]} + {2'h0, en[3]};
    endfunction : chan_count

    function automatic logic is_trig(input logic [2:0] mode);
        is_trig = !mode[2] && (mode[1:0] != 2'h0);
    endfunction : is_trig

    // interval stretches to one slot per enabled channel at fast rates
    function automatic logic [14:0] eff_interval(input logic [2:0] rate,
                                                 input logic [2:0] n);
        logic [14:0] base;
        logic [14:0] slots;
        base  = mspc_pkg::RATE_MS[rate];
        slots = 15'({12'h000, n} * mspc_pkg::SLOT_MS);
        eff_interval = (slots > base) ? slots : base;
    endfunction : eff_interval

    ////////////////////////////////////////////////////////////////////
    // flag module and its carrier
    assign fi.conv_end      = conv_end;
    assign fi.latch_mode    = latch_mode;
    assign fi.read_clr      = reg_rd && (reg_addr == mspc_pkg::ADDR_STATUS)
                              && latch_mode;
    assign fi.shunt         = shunt_result;
    assign fi.bus           = bus_result;
    assign fi.power         = power_result;
    assign fi.local_t       = local_result;
    assign fi.lim_shunt_pos = lsp_r;
    assign fi.lim_shunt_neg = lsn_r;
    assign fi.lim_bus_pos   = lbp_r;
    assign fi.lim_bus_neg   = lbn_r;
    assign fi.lim_pwr       = lpw_r;
    assign fi.lim_local     = llc_r;
    assign fi.hyst          = mspc_pkg::HYST_RESET;

    mspc_limit_flags u_flags (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .fi      (fi.flagger)
    );

    ////////////////////////////////////////////////////////////////////
    // register port: writes and reads
    always_comb begin
        cfg1_nxt     = cfg1_r;
        cfg2_nxt     = cfg2_r;
        lsp_nxt      = lsp_r;
        lsn_nxt      = lsn_r;
        lbp_nxt      = lbp_r;
        lbn_nxt      = lbn_r;
        lpw_nxt      = lpw_r;
        llc_nxt      = llc_r;
        one_shot     = 1'b0;
        rd_valid_nxt = reg_rd;
        rd_data_nxt  = rd_data_r;
        if (reg_wr) begin
            case (reg_addr)
                mspc_pkg::ADDR_CFG1: begin
                    cfg1_nxt = reg_wdata & mspc_pkg::CFG1_WMASK;
                    one_shot = reg_wdata[mspc_pkg::CFG1_ONESHOT];
                end
                mspc_pkg::ADDR_CFG2: begin
                    cfg2_nxt = reg_wdata & mspc_pkg::CFG2_WMASK; // RQ4
                end
                mspc_pkg::ADDR_SHUNT_POS: lsp_nxt = reg_wdata;
                mspc_pkg::ADDR_SHUNT_NEG: lsn_nxt = reg_wdata;
                mspc_pkg::ADDR_BUS_POS:   lbp_nxt = reg_wdata;
                mspc_pkg::ADDR_BUS_NEG:   lbn_nxt = reg_wdata;
                mspc_pkg::ADDR_PWR_LIM:   lpw_nxt = reg_wdata;
                mspc_pkg::ADDR_LOCAL_LIM: llc_nxt = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                mspc_pkg::ADDR_CFG1: rd_data_nxt = cfg1_r;
                mspc_pkg::ADDR_CFG2: begin
                    rd_data_nxt = cfg2_r;
                    rd_data_nxt[mspc_pkg::PIN_BIT] = pin_lvl_r; // RQ4
                end
                mspc_pkg::ADDR_STATUS:    rd_data_nxt = fi.flags; // RQ19
                mspc_pkg::ADDR_SHUNT_POS: rd_data_nxt = lsp_r;
                mspc_pkg::ADDR_SHUNT_NEG: rd_data_nxt = lsn_r;
                mspc_pkg::ADDR_BUS_POS:   rd_data_nxt = lbp_r;
                mspc_pkg::ADDR_BUS_NEG:   rd_data_nxt = lbn_r;
                mspc_pkg::ADDR_PWR_LIM:   rd_data_nxt = lpw_r;
                mspc_pkg::ADDR_LOCAL_LIM: rd_data_nxt = llc_r;
                default: rd_data_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cfg1_r     <= mspc_pkg::CFG1_RESET;
            cfg2_r     <= mspc_pkg::CFG2_RESET; // RQ5
            lsp_r      <= mspc_pkg::POS_RESET;
            lsn_r      <= mspc_pkg::NEG_RESET;
            lbp_r      <= mspc_pkg::UPOS_RESET;
            lbn_r      <= mspc_pkg::UNEG_RESET;
            lpw_r      <= mspc_pkg::UPOS_RESET;
            llc_r      <= mspc_pkg::POS_RESET;
            rd_data_r  <= 16'h0000;
            rd_valid_r <= 1'b0;
        end else begin
            cfg1_r     <= cfg1_nxt;
            cfg2_r     <= cfg2_nxt;
            lsp_r      <= lsp_nxt;
            lsn_r      <= lsn_nxt;
            lbp_r      <= lbp_nxt;
            lbn_r      <= lbn_nxt;
            lpw_r      <= lpw_nxt;
            llc_r      <= llc_nxt;
            rd_data_r  <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin mode and readback
    always_comb begin
        pin_lvl_nxt = pin_in; // RQ4
        pin_oe_nxt  = cfg2_r[mspc_pkg::PMODE_MSB]; // RQ5 RQ6
        pin_out_nxt = cfg2_r[mspc_pkg::PMODE_MSB:mspc_pkg::PMODE_LSB]
                      == mspc_pkg::PMODE_HIGH; // RQ6
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin_lvl_r <= 1'b0;
            pin_out_r <= 1'b0;
            pin_oe_r  <= 1'b0;
        end else begin
            pin_lvl_r <= pin_lvl_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_r  <= pin_oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // conversion interval timer and voltage triggering
    always_comb begin
        mode_now = cfg1_nxt[mspc_pkg::MODE_MSB:mspc_pkg::MODE_LSB];
        nch      = chan_count(cfg2_r[mspc_pkg::EN_MSB:mspc_pkg::EN_LSB]);
        interval = eff_interval(
            cfg2_r[mspc_pkg::RATE_MSB:mspc_pkg::RATE_LSB], nch); // RQ1 RQ2
        temp_run = cfg2_r[mspc_pkg::CFG2_CONT] && (nch != 3'h0);
        ms_tick  = tick_cnt_r == TW'(TICK_CYCLES - 1);
        tick_cnt_nxt = ms_tick ? '0 : tick_cnt_r + TW'(1);
        tick_nxt     = 1'b0;
        ms_cnt_nxt   = ms_cnt_r;
        if (!temp_run) begin
            ms_cnt_nxt = 15'h0000;
        end else if (ms_tick) begin
            if (ms_cnt_r + 15'h0001 >= interval) begin
                ms_cnt_nxt = 15'h0000;
                tick_nxt   = 1'b1; // RQ1 RQ2
            end else begin
                ms_cnt_nxt = ms_cnt_r + 15'h0001;
            end
        end
        vstart_nxt = is_trig(mode_now) && (one_shot || (tick_nxt
            && cfg2_r[mspc_pkg::RATE_MSB:mspc_pkg::RATE_LSB]
               != mspc_pkg::RATE_FASTEST)); // RQ3 RQ18
        voff_nxt = !mode_now[2] && !vstart_nxt; // RQ18
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            tick_cnt_r <= '0;
            ms_cnt_r   <= 15'h0000;
            tick_r     <= 1'b0;
            vstart_r   <= 1'b0;
            voff_r     <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            ms_cnt_r   <= ms_cnt_nxt;
            tick_r     <= tick_nxt;
            vstart_r   <= vstart_nxt;
            voff_r     <= voff_nxt;
        end
    end

    assign rd_data        = rd_data_r;
    assign rd_valid       = rd_valid_r;
    assign pin_out        = pin_out_r;
    assign pin_oe         = pin_oe_r;
    assign temp_conv_tick = tick_r;
    assign volt_start     = vstart_r;
    assign volt_off       = voff_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_pin_hiz: assert property ( // RQ5
        !cfg2_r[mspc_pkg::PMODE_MSB] |=> !pin_oe)
        else $error("pin driven in input mode");
    a_pin_drive: assert property ( // RQ6
        cfg2_r[mspc_pkg::PMODE_MSB]
        |=> pin_oe && pin_out == $past(cfg2_r[mspc_pkg::PMODE_LSB]))
        else $error("pin output level wrong");
    a_pin_readback: assert property ( // RQ4
        reg_rd && reg_addr == mspc_pkg::ADDR_CFG2
        |=> rd_data[mspc_pkg::PIN_BIT] == $past(pin_in, 2))
        else $error("readback bit does not show pin");
    a_status_old: assert property ( // RQ19
        reg_rd && reg_addr == mspc_pkg::ADDR_STATUS
        |=> rd_valid && rd_data == $past(fi.flags))
        else $error("status read lost pre-clear value");
    a_trig_gate: assert property ( // RQ3
        tick_nxt && !one_shot && is_trig(mode_now)
        && cfg2_r[mspc_pkg::RATE_MSB:mspc_pkg::RATE_LSB]
           != mspc_pkg::RATE_FASTEST |=> volt_start && !volt_off)
        else $error("temperature tick did not start voltage conversion");
    a_trig_idle: assert property ( // RQ18
        is_trig(mode_now) && !vstart_nxt |=> volt_off && !volt_start)
        else $error("triggered converter not powered down");
    c_vstart_tick: cover property (temp_conv_tick && volt_start);
    c_pin_high: cover property (pin_oe && pin_out);
endmodule : mspc_monitor_ctrl
`default_nettype wire

//--- test/mspc_host_model.sv
// host side of the decoded register port, standing for the two-wire master
// assumes ref_clk at 100 MHz; drives at falling edges only
`timescale 1ns/10ps
`default_nettype none
module mspc_host_model (
    input  wire logic        ref_clk,
    output logic      [7:0]  reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid
);
    // idle bus values at time zero
    initial begin
        reg_addr = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    // one write strobe held across one rising edge
    task wr(input logic [7:0] a, input logic [15:0] v);
        @(negedge ref_clk); reg_addr = a; reg_wdata = v; reg_wr = 1'b1;
        @(negedge ref_clk); reg_wr = 1'b0; reg_wdata = ~v;
    endtask : wr
    // one read strobe, then data taken with rd_valid
    task rd(input logic [7:0] a, output logic [15:0] v);
        int n;
        n = 0;
        @(negedge ref_clk); reg_addr = a; reg_rd = 1'b1;
        @(negedge ref_clk); reg_rd = 1'b0;
        while (rd_valid !== 1'b1 && n < 4) begin
            @(negedge ref_clk); n++;
        end
        v = rd_data;
    endtask : rd
endmodule : mspc_host_model
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the monitor status and pin control block
// assumes the host model on the register port and a short tick count
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        ref_clk, nrst, latch_mode, conv_end, pin_lvl, pin_in;
    logic [7:0]  reg_addr;
    logic        reg_wr, reg_rd, rd_valid, pin_out, pin_oe;
    logic        temp_conv_tick, volt_start, volt_off;
    logic [15:0] reg_wdata, rd_data, d, sh, bu, pw, lo;
    int          bad_count, checks;
    // pin level: design drive wins, else the board level
    assign pin_in = pin_oe ? pin_out : pin_lvl;
    mspc_monitor_ctrl #(.TICK_CYCLES(4)) i_mspc_monitor_ctrl (
        .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .rd_data(rd_data), .rd_valid(rd_valid), .latch_mode(latch_mode),
        .conv_end(conv_end), .shunt_result(sh), .bus_result(bu),
        .power_result(pw), .local_result(lo), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe),
        .temp_conv_tick(temp_conv_tick), .volt_start(volt_start),
        .volt_off(volt_off));
    mspc_host_model i_mspc_host_model (.ref_clk(ref_clk),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .rd_data(rd_data), .rd_valid(rd_valid));
    ////////////////////////////////////////////////////////////////////
    // helpers
    task chk(input logic [15:0] g, input logic [15:0] e, input string m);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask : chk
    task rdc(input logic [7:0] a, input logic [15:0] e, input string m);
        i_mspc_host_model.rd(a, d);
        chk({15'h0, rd_valid}, 16'h0001, "read valid");
        chk(d, e, m);
    endtask : rdc
    task conv;
        @(negedge ref_clk); conv_end = 1'b1;
        @(negedge ref_clk); conv_end = 1'b0;
    endtask : conv
    task wait_tick(output int n);
        n = 1;
        @(negedge ref_clk);
        while (temp_conv_tick !== 1'b1 && n < 5000) begin
            @(negedge ref_clk); n++;
        end
        chk({15'h0, temp_conv_tick}, 16'h0001, "tick seen");
    endtask : wait_tick
    task meas(input logic [15:0] cfg, input int ms);
        int n;
        i_mspc_host_model.wr(mspc_pkg::ADDR_CFG2, cfg);
        wait_tick(n);
        wait_tick(n);
        chk(16'(n), 16'(ms * 4), "interval");
    endtask : meas
    ////////////////////////////////////////////////////////////////////
    // scenarios
    task t_reset;
        rdc(mspc_pkg::ADDR_CFG2, 16'hff84, "cfg2 reset");
        chk({15'h0, pin_oe}, 16'h0, "pin idle");
        chk({15'h0, volt_off}, 16'h0, "volt on");
        rdc(mspc_pkg::ADDR_STATUS, 16'h0, "status reset");
    endtask : t_reset
    task t_pin;
        for (int m = 0; m < 4; m++) begin
            pin_lvl = m[1] ? ~m[0] : m[0];
            i_mspc_host_model.wr(mspc_pkg::ADDR_CFG2, {14'h3fe1, m[1:0]});
            repeat (3) @(negedge ref_clk);
            chk({15'h0, pin_oe}, {15'h0, m[1]}, "pin drive");
            chk({15'h0, pin_out | ~m[1]}, {15'h0, m[0] | ~m[1]}, "lvl");
            rdc(mspc_pkg::ADDR_CFG2, {13'h1ff0, m[0], m[1:0]}, "rb");
        end
        i_mspc_host_model.wr(mspc_pkg::ADDR_CFG2, 16'hff80);
    endtask : t_pin
    task t_latch;
        latch_mode = 1'b1;
        i_mspc_host_model.wr(mspc_pkg::ADDR_SHUNT_POS, 16'h0010);
        i_mspc_host_model.wr(mspc_pkg::ADDR_SHUNT_NEG, 16'hfff0);
        i_mspc_host_model.wr(mspc_pkg::ADDR_BUS_POS, 16'h1000);
        i_mspc_host_model.wr(mspc_pkg::ADDR_BUS_NEG, 16'h0100);
        i_mspc_host_model.wr(mspc_pkg::ADDR_PWR_LIM, 16'h0100);
        rdc(mspc_pkg::ADDR_STATUS, 16'h0, "after setup");
        sh = 16'h0020; bu = 16'h2000; pw = 16'h0200;
        conv;
        rdc(mspc_pkg::ADDR_STATUS, 16'ha800, "over");
        rdc(mspc_pkg::ADDR_STATUS, 16'h0, "cleared");
        conv;
        rdc(mspc_pkg::ADDR_STATUS, 16'ha800, "set again");
        sh = 16'hff00; bu = 16'h0010; pw = 16'h0000;
        conv;
        rdc(mspc_pkg::ADDR_STATUS, 16'h5000, "under");
        rdc(mspc_pkg::ADDR_STATUS, 16'h0, "cleared");
    endtask : t_latch
    task t_transp;
        latch_mode = 1'b0;
        sh = 16'h0020; bu = 16'h2000; pw = 16'h0200;
        repeat (3) @(negedge ref_clk);
        rdc(mspc_pkg::ADDR_STATUS, 16'ha800, "live");
        sh = 16'h0000; bu = 16'h0400; pw = 16'h0000;
        repeat (3) @(negedge ref_clk);
        rdc(mspc_pkg::ADDR_STATUS, 16'h0, "dropped");
        i_mspc_host_model.wr(mspc_pkg::ADDR_LOCAL_LIM, 16'h0100);
        lo = 16'h0110;
        repeat (3) @(negedge ref_clk);
        rdc(mspc_pkg::ADDR_STATUS, 16'h0400, "local set");
        lo = 16'h0100;
        rdc(mspc_pkg::ADDR_STATUS, 16'h0400, "local hold");
        lo = 16'h00f0;
        repeat (3) @(negedge ref_clk);
        rdc(mspc_pkg::ADDR_STATUS, 16'h0, "local clr");
    endtask : t_transp
    task t_trig;
        int n;
        i_mspc_host_model.wr(mspc_pkg::ADDR_CFG1, 16'h0003);
        i_mspc_host_model.wr(mspc_pkg::ADDR_CFG2, 16'h8b00);
        wait_tick(n);
        chk({15'h0, volt_start}, 16'h1, "auto start");
        @(negedge ref_clk);
        chk({15'h0, volt_off}, 16'h1, "powered down");
        i_mspc_host_model.wr(mspc_pkg::ADDR_CFG2, 16'h8b80);
        wait_tick(n);
        chk({15'h0, volt_start}, 16'h0, "no start at 111");
        i_mspc_host_model.wr(mspc_pkg::ADDR_CFG1, 16'h4001);
        n = 0;
        while (volt_start !== 1'b1 && n < 4) begin
            @(negedge ref_clk); n++;
        end
        chk({15'h0, volt_start}, 16'h1, "one-shot");
    endtask : t_trig
    ////////////////////////////////////////////////////////////////////
    // verdict, clock, watchdog and main sequence
    task results;
        $display("mismatches %0d comparisons %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #500us;
        bad_count++;
        results;
    end
    initial begin
        bad_count = 0; checks = 0; nrst = 1'b0; latch_mode = 1'b1;
        conv_end = 1'b0; pin_lvl = 1'b1;
        sh = 16'h0; bu = 16'h0; pw = 16'h0; lo = 16'h0;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk); nrst = 1'b1;
        t_reset;
        t_pin;
        t_latch;
        t_transp;
        meas(16'hbb00, 375);
        meas(16'hfb00, 500);
        meas(16'h9b80, 250);
        meas(16'hbb80, 375);
        t_trig;
        results;
    end
endmodule : tb
`default_nettype wire
